// ### verilog/wdt_timeout_counter.sv
// Watchdog timeout counter: prescaler, counter and reset pulse.
// Summary of operation
// - Six-bit counter advanced by twelve-bit prescaler on the crystal clock.
// - Overflow raises reset; short period when long select low, long when high.
// - Any write to clear location zeroes counter and prescaler upper stages.
// - Timeout drives reset pin low 32 cycles and sets cause flag.
// - Monitor mode with high voltage on reset or interrupt pin disables.
// - Break state with high voltage on reset pin disables watchdog.
// - Stop instruction clears the prescaler.
// - Reading clear location returns reset vector, no effect on watchdog.
// - Power-on logic clears prescaler 4096 crystal cycles after power-up.
// - Internal reset clears prescaler and counter.
// - Reset vector fetch clears the prescaler.
// - Disable input follows config bit; no counting or reset while set.
// - Long select input follows config bit and picks overflow period.
// - Prescaler runs from crystal clock, not the bus clock.
// - No interrupt request; timeout only resets.
// - In stop mode the watchdog does not advance.
`timescale 1ns/10ps
`default_nettype none
`include "wdt_defs.svh"
module wdt_timeout_counter
	import wdt_pkg::*;
(
	input  wire logic      clk_i,
	input  wire logic      rst_n_i,
	input  wire wdt_ctrl_s ctrl_i,
	input  wire wdt_bus_s  bus_i,
	input  wire logic [7:0] reset_vector_low_i,
	input  wire logic      hv_rst_pin_i,
	input  wire logic      hv_irq_pin_i,
	input  wire logic      cause_clear_i,
	output logic      [7:0] rd_data_o,
	output logic           rst_pin_o,
	output logic           rst_pin_oe_o,
	output logic           cause_flag_o
);
	logic [`WDT_SYNC_W-1:0] hv_level;
	logic [`WDT_PRE_W-1:0]  pre_reg;
	logic [`WDT_PRE_W-1:0]  pre_next;
	logic [`WDT_CNT_W-1:0]  cnt_reg;
	logic [`WDT_CNT_W-1:0]  cnt_next;
	logic [12:0]            por_reg;
	logic [12:0]            por_next;
	logic                   por_done_reg;
	logic                   por_done_next;
	logic [4:0]             pulse_reg;
	logic [4:0]             pulse_next;
	wdt_state_e             state_reg;
	wdt_state_e             state_next;
	logic                   oe_next;
	logic                   cause_next;
	logic [7:0]             rd_next;
	logic                   clr_wr;
	logic                   clr_rd;
	logic                   wd_off;
	logic                   carry;
	logic                   wrap;
	logic                   por_clear;

	// True when the prescaler carries out of the selected tap stage.
	function automatic logic tap_carry(input logic [`WDT_PRE_W-1:0] p,
	                                   input logic long_sel);
		logic [`WDT_PRE_W-1:0] mask;
		mask = long_sel ? {`WDT_PRE_W{1'b1}} >> (`WDT_PRE_W-1-`WDT_LONG_TAP)
		                : {`WDT_PRE_W{1'b1}} >> (`WDT_PRE_W-1-`WDT_SHORT_TAP);
		return (p & mask) == mask;
	endfunction

	wdt_pin_sync u_sync (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.pin_i   ({hv_irq_pin_i, hv_rst_pin_i}),
		.level_o (hv_level)
	);

	assign clr_wr = bus_i.wr && (bus_i.addr == `WDT_CLEAR_ADDR);
	assign clr_rd = bus_i.rd && (bus_i.addr == `WDT_CLEAR_ADDR);
	// High-voltage detection gates the watchdog off in debug modes.
	assign wd_off = ctrl_i.watchdog_disable
	              || (ctrl_i.monitor_mode && (hv_level != '0))
	              || (ctrl_i.break_state && hv_level[0]);
	assign carry = tap_carry(pre_reg, ctrl_i.long_timeout_select);
	assign wrap  = (state_reg == WDT_ST_RUN) && !wd_off && !ctrl_i.stop_mode
	             && carry && (cnt_reg == `WDT_CNT_MAX);
	assign por_clear = !por_done_reg && (por_reg == `WDT_POR_LAST);

	// Clocking is the crystal clock itself, so one step per edge.
	always_comb begin
		pre_next      = pre_reg;
		cnt_next      = cnt_reg;
		por_next      = por_reg;
		por_done_next = por_done_reg;
		if (!por_done_reg) begin
			por_next = por_reg + 13'h0001;
		end
		if (por_clear) begin
			por_done_next = 1'b1;
		end
		if (ctrl_i.internal_reset || state_reg == WDT_ST_PULSE || wrap) begin
			pre_next = '0;
			cnt_next = '0;
		end else if (ctrl_i.stop_instr || ctrl_i.vector_fetch || por_clear) begin
			pre_next = '0;
			// A clear write in the same cycle must still zero the counter.
			if (clr_wr) begin
				cnt_next = '0;
			end
		end else if (clr_wr) begin
			cnt_next = '0;
			pre_next = {pre_reg[`WDT_PRE_W-1:`WDT_PRE_CLR_LO] & '0,
			            pre_reg[`WDT_PRE_CLR_LO-1:0]};
		end else if (!wd_off && !ctrl_i.stop_mode) begin
			pre_next = pre_reg + 12'h001;
			if (carry) begin
				cnt_next = cnt_reg + 6'h01;
			end
		end
	end

	// A wrap starts the reset pulse; the block has no interrupt path.
	always_comb begin
		state_next = state_reg;
		pulse_next = pulse_reg;
		oe_next    = 1'b0;
		cause_next = cause_flag_o;
		rd_next    = rd_data_o;
		if (cause_clear_i) begin
			cause_next = 1'b0;
		end
		if (clr_rd) begin
			rd_next = reset_vector_low_i;
		end
		case (state_reg)
			WDT_ST_RUN: begin
				if (wrap) begin
					state_next = WDT_ST_PULSE;
					pulse_next = '0;
					oe_next    = 1'b1;
					cause_next = 1'b1;
				end
			end
			WDT_ST_PULSE: begin
				if (pulse_reg == `WDT_PULSE_LAST) begin
					state_next = WDT_ST_RUN;
				end else begin
					pulse_next = pulse_reg + 5'h01;
					oe_next    = 1'b1;
				end
			end
			default: begin
				state_next = WDT_ST_RUN;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pre_reg      <= '0;
			cnt_reg      <= '0;
			por_reg      <= '0;
			por_done_reg <= 1'b0;
			pulse_reg    <= '0;
			state_reg    <= WDT_ST_RUN;
			rst_pin_oe_o <= 1'b0;
			rst_pin_o    <= 1'b0;
			cause_flag_o <= 1'b0;
			rd_data_o    <= 8'h00;
		end else begin
			pre_reg      <= pre_next;
			cnt_reg      <= cnt_next;
			por_reg      <= por_next;
			por_done_reg <= por_done_next;
			pulse_reg    <= pulse_next;
			state_reg    <= state_next;
			rst_pin_oe_o <= oe_next;
			rst_pin_o    <= 1'b0;
			cause_flag_o <= cause_next;
			rd_data_o    <= rd_next;
		end
	end

	property p_pulse_len;
		@(posedge clk_i) disable iff (!rst_n_i)
		$rose(rst_pin_oe_o) |-> rst_pin_oe_o ##31 rst_pin_oe_o ##1 !rst_pin_oe_o;
	endproperty
	a_pulse_len: assert property (p_pulse_len) else $error("reset pulse not 32 cycles");

	property p_cause_set;
		@(posedge clk_i) disable iff (!rst_n_i)
		wrap |=> cause_flag_o && rst_pin_oe_o && !rst_pin_o;
	endproperty
	a_cause_set: assert property (p_cause_set) else $error("timeout without cause flag");

	property p_clear_write;
		@(posedge clk_i) disable iff (!rst_n_i)
		clr_wr && !ctrl_i.internal_reset && state_reg == WDT_ST_RUN
		|=> cnt_reg == '0 && pre_reg[`WDT_PRE_W-1:`WDT_PRE_CLR_LO] == '0;
	endproperty
	a_clear_write: assert property (p_clear_write) else $error("clear write missed");

	property p_stop_clear;
		@(posedge clk_i) disable iff (!rst_n_i)
		ctrl_i.stop_instr |=> pre_reg == '0;
	endproperty
	a_stop_clear: assert property (p_stop_clear) else $error("stop left prescaler");

	property p_fetch_clear;
		@(posedge clk_i) disable iff (!rst_n_i)
		ctrl_i.vector_fetch |=> pre_reg == '0;
	endproperty
	a_fetch_clear: assert property (p_fetch_clear) else $error("fetch left prescaler");

	property p_int_reset;
		@(posedge clk_i) disable iff (!rst_n_i)
		ctrl_i.internal_reset |=> pre_reg == '0 && cnt_reg == '0;
	endproperty
	a_int_reset: assert property (p_int_reset) else $error("internal reset ignored");

	property p_off_hold;
		@(posedge clk_i) disable iff (!rst_n_i)
		(wd_off || ctrl_i.stop_mode) && state_reg == WDT_ST_RUN
		&& !ctrl_i.internal_reset |=> !$rose(rst_pin_oe_o) && cnt_reg <= $past(cnt_reg);
	endproperty
	a_off_hold: assert property (p_off_hold) else $error("disabled watchdog moved");

	property p_read_vec;
		@(posedge clk_i) disable iff (!rst_n_i)
		clr_rd && !clr_wr && state_reg == WDT_ST_RUN && wd_off
		&& !ctrl_i.internal_reset |=> rd_data_o == $past(reset_vector_low_i)
		&& cnt_reg == $past(cnt_reg);
	endproperty
	a_read_vec: assert property (p_read_vec) else $error("read of clear location wrong");

	property p_por_clear;
		@(posedge clk_i) disable iff (!rst_n_i)
		por_clear |=> pre_reg == '0 && por_done_reg ##1 por_done_reg;
	endproperty
	a_por_clear: assert property (p_por_clear) else $error("power-on clear missed");
endmodule
`default_nettype wire

// ### verilog/wdt_defs.svh
// Constants for the watchdog timeout counter.
`ifndef WDT_DEFS_SVH
`define WDT_DEFS_SVH

`define WDT_CLK_HZ       25000000
`define WDT_PRE_W        12
`define WDT_CNT_W        6
`define WDT_PRE_CLR_LO   3
`define WDT_SHORT_TAP    6
`define WDT_LONG_TAP     11
`define WDT_CNT_MAX      6'h3F
`define WDT_CLEAR_ADDR   16'hFFFF
`define WDT_PULSE_CYC    32
`define WDT_PULSE_LAST   5'h1F
`define WDT_POR_CYC      4096
`define WDT_POR_LAST     13'h0FFF
`define WDT_SYNC_W       2

`endif

// ### verilog/wdt_pkg.sv
// Types shared by the watchdog timeout counter files.
package wdt_pkg;

	typedef struct packed {
		logic watchdog_disable;
		logic long_timeout_select;
		logic stop_mode;
		logic stop_instr;
		logic monitor_mode;
		logic break_state;
		logic internal_reset;
		logic vector_fetch;
	} wdt_ctrl_s;

	typedef struct packed {
		logic [15:0] addr;
		logic        wr;
		logic        rd;
	} wdt_bus_s;

	typedef enum logic [1:0] {
		WDT_ST_RUN   = 2'b01,
		WDT_ST_PULSE = 2'b10
	} wdt_state_e;

endpackage

// ### verilog/wdt_pin_sync.sv
// Three-flop synchroniser with agreement filter for pin levels.
`timescale 1ns/10ps
`default_nettype none
`include "wdt_defs.svh"
module wdt_pin_sync (
	input  wire logic                   clk_i,
	input  wire logic                   rst_n_i,
	input  wire logic [`WDT_SYNC_W-1:0] pin_i,
	output logic      [`WDT_SYNC_W-1:0] level_o
);
	logic [`WDT_SYNC_W-1:0] s1_reg;
	logic [`WDT_SYNC_W-1:0] s2_reg;
	logic [`WDT_SYNC_W-1:0] s3_reg;
	logic [`WDT_SYNC_W-1:0] level_next;

	// A bit changes only once the second and third stages agree.
	always_comb begin
		for (int i = 0; i < `WDT_SYNC_W; i++) begin
			level_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : level_o[i];
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s1_reg  <= '0;
			s2_reg  <= '0;
			s3_reg  <= '0;
			level_o <= '0;
		end else begin
			s1_reg  <= pin_i;
			s2_reg  <= s1_reg;
			s3_reg  <= s2_reg;
			level_o <= level_next;
		end
	end
endmodule
`default_nettype wire

// ### verif/tb_wdt_timeout_counter.sv
// Self-checking testbench for the watchdog timeout counter.
`timescale 1ns/10ps
`default_nettype none
module tb_wdt_timeout_counter;
	import wdt_pkg::*;

	logic       clk_i        = 1'b0;
	logic       rst_n_i      = 1'b0;
	wdt_ctrl_s  ctrl         = '0;
	wdt_bus_s   bus          = '0;
	logic [7:0] vec          = 8'hA5;
	logic       hv_rst       = 1'b0;
	logic       hv_irq       = 1'b0;
	logic       cclr         = 1'b0;
	int         oe_cyc       = 0;
	logic [7:0] rd_data;
	logic       pin;
	logic       pin_oe;
	logic       cause;
	int         mismatches   = 0;
	int         total_checks = 0;
	// Hold cases: disable, stop, monitor twice, break on reset pin, long period; break on interrupt pin must fire.
	logic [7:0] cv [7] = '{8'h80, 8'h20, 8'h08, 8'h08, 8'h04, 8'h04, 8'h40};
	// Keep-alive pulses: bus write, stop, vector fetch, internal reset.
	logic [7:0] pv [4] = '{8'h00, 8'h10, 8'h01, 8'h02};

	always #20 clk_i = ~clk_i;

	// Counts every cycle the reset pin is driven, for the keep-alive tests.
	always @(posedge clk_i) begin
		if (pin_oe !== 1'b0) begin
			oe_cyc <= oe_cyc + 1;
		end
	end

	wdt_timeout_counter u_wdt_timeout_counter (
		.clk_i              (clk_i),
		.rst_n_i            (rst_n_i),
		.ctrl_i             (ctrl),
		.bus_i              (bus),
		.reset_vector_low_i (vec),
		.hv_rst_pin_i       (hv_rst),
		.hv_irq_pin_i       (hv_irq),
		.cause_clear_i      (cclr),
		.rd_data_o          (rd_data),
		.rst_pin_o          (pin),
		.rst_pin_oe_o       (pin_oe),
		.cause_flag_o       (cause)
	);

	task automatic check(input logic [31:0] got, input logic [31:0] exp,
			input string msg);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: %s got %0h expected %0h",
				$time, msg, got, exp);
		end
	endtask

	// Inputs always move 2 ns after the edge so sampling never races.
	task automatic cyc(input int k);
		repeat (k) @(posedge clk_i);
		#2;
	endtask

	task automatic clr();
		bus = '{16'hFFFF, 1'b1, 1'b0};
		cyc(1);
		bus = '0;
	endtask

	task automatic fire(input int lim, output int c);
		c = 0;
		while (pin_oe !== 1'b1 && c < lim) begin
			cyc(1);
			c++;
		end
	endtask

	// Reads run with the watchdog disabled so the counter must stand still.
	task automatic t_read();
		ctrl = wdt_ctrl_s'(8'h80);
		bus = '{16'hFFFF, 1'b0, 1'b1};
		cyc(1);
		bus = '0;
		check(rd_data, 8'hA5, "vector read");
		vec = 8'h3C;
		bus = '{16'hFFFE, 1'b0, 1'b1};
		cyc(1);
		bus = '0;
		check(rd_data, 8'hA5, "other address read");
		ctrl = '0;
		$display("test read done");
	endtask

	task automatic t_timeout();
		int c;
		int n;
		clr();
		fire(9000, c);
		// Stages 0-2 survive the clear, so up to seven cycles may be lost.
		check(c >= 8185 && c <= 8194, 1'b1, "short period");
		check(pin, 1'b0, "pin drive level");
		check(cause, 1'b1, "cause flag");
		n = 0;
		while (pin_oe === 1'b1 && n < 40) begin
			cyc(1);
			n++;
		end
		check(n, 32, "pulse width");
		cclr = 1'b1;
		cyc(1);
		cclr = 1'b0;
		cyc(1);
		check(cause, 1'b0, "cause cleared");
		$display("test timeout done");
	endtask

	// Pulses every 81 cycles never let the 128-cycle tap carry.
	task automatic keep(input int w);
		int s;
		clr();
		s = oe_cyc;
		repeat (102) begin
			cyc(80);
			if (w == 0) bus = '{16'hFFFF, 1'b1, 1'b0};
			else ctrl = wdt_ctrl_s'(pv[w]);
			cyc(1);
			bus = '0;
			ctrl = '0;
		end
		check(oe_cyc - s, 0, "kept alive");
		$display("test keep %0d done", w);
	endtask

	task automatic hold(input int w, input logic f);
		int c;
		ctrl = wdt_ctrl_s'(cv[w]);
		hv_rst = (w == 2 || w == 4);
		hv_irq = (w == 3 || w == 5);
		cyc(10);
		clr();
		fire(8220, c);
		check(pin_oe, f, "hold case");
		ctrl = '0;
		hv_rst = 1'b0;
		hv_irq = 1'b0;
		cyc(40);
		$display("test hold %0d done", w);
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	initial begin
		cyc(20);
		rst_n_i = 1'b1;
		t_read();
		// Let the power-on prescaler clear pass before timing anything.
		cyc(4100);
		t_timeout();
		for (int w = 0; w < 4; w++) keep(w);
		for (int w = 0; w < 7; w++) hold(w, w == 5);
		summarize();
	end

	initial begin
		#4600000;
		mismatches++;
		summarize();
	end
endmodule
`default_nettype wire
